// ---- bench/ari_master.sv ----
`timescale 1ns/1ps
module ari_master (
  output logic       scl,
  output logic       sda_low,
  input  wire logic  sda,
  output logic [7:0] rd_byte,
  output logic       rd_stb
);
  initial begin
    scl     = 1'b1;
    sda_low = 1'b0;
    rd_byte = 8'h00;
    rd_stb  = 1'b0;
  end

  // SDA moves only while SCL is low, so no data bit looks like a START.
  task automatic bit_io(input logic b, output logic s);
    sda_low = ~b;
    #8 scl = 1'b1;
    #14 s = sda;
    #1 scl = 1'b0;
    #7;
  endtask

  task automatic idle(input int n);
    sda_low = 1'b0;
    repeat (n) begin
      #15 scl = 1'b0;
      #15 scl = 1'b1;
    end
  endtask

  task automatic start();
    sda_low = 1'b0;
    #8 scl = 1'b1;
    #8 sda_low = 1'b1;
    #15 scl = 1'b0;
    #7;
  endtask

  task automatic stop();
    sda_low = 1'b1;
    #8 scl = 1'b1;
    #15 sda_low = 1'b0;
    #15;
  endtask

  task automatic put(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(b[i], s);
    bit_io(1'b1, s);
    ack = ~s;
  endtask

  // acknowledge to go on, not-acknowledge on the last
  task automatic get(input logic last);
    logic [7:0] v;
    logic       s;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, v[i]);
    bit_io(last, s);
    rd_byte = v;
    rd_stb = 1'b1;
    #1 rd_stb = 1'b0;
  endtask
endmodule

// ---- bench/ari_regs_chk.sv ----
`timescale 1ns/1ps
module ari_regs_chk (
  input wire logic       ref_clk,
  input wire logic       sys_rst,
  input wire logic       scl,
  input wire logic       sda_oe,
  input wire logic       int_n_oe,
  input wire logic       audio_detect,
  input wire logic       clip_detect,
  input wire logic       jack_sense,
  input wire logic       overheat,
  input wire logic       zero_cross,
  input wire logic [3:0] port0_config,
  input wire logic [3:0] port1_config,
  input wire logic [3:0] left_gain,
  input wire logic [3:0] right_gain,
  input wire logic       mute,
  input wire logic       power_down
);
  // Ages count reference cycles since a cause last moved, saturating at 7.
  // Outputs may only move shortly after bus clocks, events or crossings.
  logic [5:0] last_ff;
  logic [5:0] nxt_last;
  logic [2:0] scl_age_ff, zc_age_ff, ev_age_ff;
  logic [2:0] nxt_scl_age, nxt_zc_age, nxt_ev_age;

  function automatic logic [2:0] bump(input logic hit, input logic [2:0] a);
    return hit ? 3'h0 : ((a == 3'h7) ? a : a + 3'h1);
  endfunction

  always_comb begin
    nxt_last = {scl, zero_cross, audio_detect, clip_detect, jack_sense,
                overheat};
    nxt_scl_age = sys_rst ? 3'h7 : bump(scl != last_ff[5], scl_age_ff);
    nxt_zc_age = sys_rst ? 3'h7 : bump(zero_cross && !last_ff[4], zc_age_ff);
    nxt_ev_age = sys_rst ? 3'h7 : bump(nxt_last[3:0] != last_ff[3:0],
                                       ev_age_ff);
  end

  always_ff @(posedge ref_clk) begin
    last_ff    <= nxt_last;
    scl_age_ff <= nxt_scl_age;
    zc_age_ff  <= nxt_zc_age;
    ev_age_ff  <= nxt_ev_age;
  end

  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);

  chk_rst_quiet: assert property (
    $fell(sys_rst) |-> !int_n_oe && !sda_oe)
    else $error("driver active right after reset");
  chk_hot_irq: assert property (
    $rose(overheat) |-> ##[1:6] int_n_oe)
    else $error("overheat did not raise the interrupt");
  chk_irq_cause: assert property (
    $rose(int_n_oe) |-> ev_age_ff <= 3'h6)
    else $error("interrupt without a recent event");
  chk_irq_release: assert property (
    $fell(int_n_oe) |-> scl_age_ff <= 3'h6)
    else $error("interrupt released without bus traffic");
  chk_irq_latched: assert property (
    int_n_oe ##1 (scl_age_ff == 3'h7) [*2] |-> int_n_oe)
    else $error("interrupt dropped while bus idle");
  chk_mode_src: assert property (
    $changed({mute, power_down}) |-> scl_age_ff <= 3'h6)
    else $error("mode outputs moved without a write");
  chk_cfg_src: assert property (
    $changed({port1_config, port0_config}) |-> scl_age_ff <= 3'h6)
    else $error("port config moved without a write");
  chk_gain_src: assert property (
    $changed({left_gain, right_gain})
      |-> scl_age_ff <= 3'h6 || zc_age_ff <= 3'h6)
    else $error("gain moved without write or crossing");
endmodule

bind ari_regs ari_regs_chk ari_regs_chk_inst (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .scl(scl), .sda_oe(sda_oe),
  .int_n_oe(int_n_oe), .audio_detect(audio_detect),
  .clip_detect(clip_detect), .jack_sense(jack_sense), .overheat(overheat),
  .zero_cross(zero_cross), .port0_config(port0_config),
  .port1_config(port1_config), .left_gain(left_gain),
  .right_gain(right_gain), .mute(mute), .power_down(power_down)
);

// ---- bench/tb.sv ----
`timescale 1ns/1ps
module tb;
  localparam logic [2:0] DIE = 3'h5; // Arbitrary value.
  logic       ref_clk = 1'b0;
  logic       sys_rst = 1'b1;
  logic [3:0] src     = 4'h0;
  logic       zc      = 1'b0;
  logic [7:0] cmp     = 8'h00;
  logic       int_low = 1'b0;
  logic [7:0] rnd     = 8'h0a;
  logic [7:0] g, e8, rd_byte;
  logic       scl, sda_low, sda_oe, int_n_oe, rd_stb, mute, power_down;
  logic [3:0] pc0, pc1, pc2, pc3, lg, rg;
  wire        sda   = ~(sda_low | sda_oe);
  wire        int_n = ~(int_n_oe | int_low);
  int         n_errors = 0;
  int         total_checks = 0;
  logic [7:0] exp_q[$];

  ari_regs #(.DIE_CODE(DIE)) ari_regs_inst (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .scl(scl), .sda_in(sda),
    .sda_out(), .sda_oe(sda_oe), .int_n_in(int_n), .int_n_out(),
    .int_n_oe(int_n_oe), .audio_detect(src[3]), .clip_detect(src[2]),
    .jack_sense(src[1]), .overheat(src[0]), .zero_cross(zc),
    .comp_upper(cmp[7:4]), .comp_lower(cmp[3:0]), .port0_config(pc0),
    .port1_config(pc1), .port2_config(pc2), .port3_config(pc3),
    .left_gain(lg), .right_gain(rg), .mute(mute), .power_down(power_down));
  ari_master ari_master_inst (.scl(scl), .sda_low(sda_low), .sda(sda),
    .rd_byte(rd_byte), .rd_stb(rd_stb));

  always #10 ref_clk = ~ref_clk;

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen %h want %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #2;
  endtask

  task automatic tx(input logic [7:0] b, input logic ea);
    logic a;
    ari_master_inst.put(b, a);
    chk({7'h0, a}, {7'h0, ea});
  endtask

  task automatic wr(input logic [39:0] w, input int n, input logic ea);
    ari_master_inst.start();
    for (int i = n - 1; i >= 0; i--) tx(w[8*i+:8], (i == n - 1) ? ea : ea);
    ari_master_inst.stop();
    tick(6);
  endtask

  task automatic rd(input logic [7:0] dv, input logic [7:0] ra,
                    input int n, input logic [55:0] e);
    for (int i = n - 1; i >= 0; i--) exp_q.push_back(e[8*i+:8]);
    ari_master_inst.start();
    tx(dv, 1'b1);
    tx(ra, 1'b1);
    ari_master_inst.start();
    tx(dv | 8'h01, 1'b1);
    for (int i = n - 1; i >= 0; i--) ari_master_inst.get(i == 0);
    ari_master_inst.stop();
    tick(6);
  endtask

  always @(posedge rd_stb) chk(rd_byte, exp_q.pop_front());

  initial begin
    #400000;
    n_errors++;
    report_and_stop();
  end

  initial begin
    fork
      tick(16);
      begin
        // The SDA-edge flops clear only once the link reset has arrived.
        #5 ari_master_inst.idle(4);
        ari_master_inst.start();
        ari_master_inst.stop();
      end
    join
    sys_rst = 1'b0;
    tick(4);
    ari_master_inst.idle(3);
    rd(8'hd0, 8'h00, 7, {13'h0, DIE, 40'h0});
    $display("test reset_values done");
    rnd = lfsr(rnd);
    g = rnd;
    // sensing ports are set up before any jack enable
    wr({8'hd0, 8'h04, 8'hee, 8'hee, g}, 5, 1'b1);
    chk({pc1, pc0}, 8'hee);
    chk({pc3, pc2}, 8'hee);
    chk({lg, rg}, g);
    rnd = lfsr(rnd);
    cmp = rnd;
    tick(8);
    for (int i = 0; i < 4; i++) e8[2*i+:2] = {cmp[4+i], cmp[i]};
    rd(8'hd0, 8'h00, 7, {e8, 5'h0, DIE, 16'h0, 8'hee, 8'hee, g});
    // Port 0 switched off and port 1 set to diode both hide their results.
    wr({8'hd0, 8'h04, 8'hf0}, 3, 1'b1);
    chk({pc1, pc0}, 8'hf0);
    rd(8'hd0, 8'h00, 1, {48'h0, e8[7:4], 4'h0});
    $display("test burst done");
    // unused control bits written as zero
    wr({8'hd0, 8'h02, 8'he3}, 3, 1'b1);
    chk({6'h0, mute, power_down}, 8'h03);
    rd(8'hd0, 8'h02, 1, 56'he3);
    wr({8'hd0, 8'h02, 8'h04}, 3, 1'b1);
    chk({6'h0, mute, power_down}, 8'h00);
    wr({8'hd0, 8'h06, ~g}, 3, 1'b1);
    chk({lg, rg}, g);
    zc = 1'b1;
    tick(4);
    zc = 1'b0;
    tick(6);
    chk({lg, rg}, ~g);
    $display("test control done");
    for (int k = 0; k < 4; k++) begin
      wr({8'hd0, 8'h02, (k < 3) ? (8'h80 >> k) : 8'h00}, 3, 1'b1);
      src[3-k] = 1'b1;
      tick(8);
      chk({7'h0, int_n_oe}, 8'h01);
      rd(8'hd0, 8'h02, 1, 56'h0);
      rd(8'hd0, 8'h01, 1, {48'h0, (8'h80 >> k) | {5'h0, DIE}});
      chk({7'h0, int_n_oe}, 8'h00);
      src = 4'h0;
      tick(8);
    end
    src[3] = 1'b1;
    tick(8);
    chk({7'h0, int_n_oe}, 8'h00);
    rd(8'hd0, 8'h01, 1, {48'h0, 5'h10, DIE});
    src = 4'h0;
    $display("test events done");
    wr({8'hd2, 8'h02, 8'h00}, 3, 1'b0);
    wr({8'hd0, 8'h03, 8'h01}, 3, 1'b1);
    wr({8'hd2, 8'h02, 8'h00}, 3, 1'b0);
    // interrupt line held low across the whole write
    int_low = 1'b1;
    tick(2);
    wr({8'hd0, 8'h03, 8'h01}, 3, 1'b1);
    int_low = 1'b0;
    rd(8'hd2, 8'h03, 1, 56'h01);
    wr({8'hd0, 8'h02, 8'h00}, 3, 1'b0);
    $display("test address done");
    report_and_stop();
  end
endmodule

// ---- common/ari_pkg.sv ----
package ari_pkg;
  localparam logic [7:0] REG_COMP    = 8'h00;
  localparam logic [7:0] REG_EVENT   = 8'h01;
  localparam logic [7:0] REG_CTRL    = 8'h02;
  localparam logic [7:0] REG_ADDR    = 8'h03;
  localparam logic [7:0] REG_DIAG_LO = 8'h04;
  localparam logic [7:0] REG_DIAG_HI = 8'h05;
  localparam logic [7:0] REG_GAIN    = 8'h06;
  localparam logic [7:0] RST_BYTE    = 8'h00;
  localparam logic [7:0] CTRL_MASK   = 8'he7;
  localparam logic [4:0] SLAVE_BASE  = 5'h1a;
  localparam logic [1:0] SEL_RST     = 2'h0;
  localparam logic [3:0] CFG_OFF     = 4'h0;
  localparam logic [3:0] CFG_DIODE   = 4'hf;
  localparam logic [3:0] BIT_LAST    = 4'h7;
  localparam logic [3:0] BIT_ACK     = 4'h8;
  localparam int         CTRL_AUD    = 7;
  localparam int         CTRL_CLIP   = 6;
  localparam int         CTRL_JACK   = 5;
  localparam int         CTRL_ZC     = 2;
  localparam int         CTRL_MUTE   = 1;
  localparam int         CTRL_PD     = 0;
  localparam int         FL_AUD      = 3;
  localparam int         FL_CLIP     = 2;
  localparam int         FL_JACK     = 1;
  localparam int         FL_HOT      = 0;
  localparam int         PIN_SYNC_W  = 14;
  localparam int         TGL_SYNC_W  = 4;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_DEVADDR,
    ST_REGADDR,
    ST_WDATA,
    ST_RDATA
  } ari_state_t;
endpackage

// ---- logic/ari_regs.sv ----
`timescale 1ns/1ps
module ari_regs #(
  parameter logic [2:0] DIE_CODE = 3'h6 // Arbitrary value.
) (
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  input  wire logic       scl,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  input  wire logic       int_n_in,
  output logic            int_n_out,
  output logic            int_n_oe,
  input  wire logic       audio_detect,
  input  wire logic       clip_detect,
  input  wire logic       jack_sense,
  input  wire logic       overheat,
  input  wire logic       zero_cross,
  input  wire logic [3:0] comp_upper,
  input  wire logic [3:0] comp_lower,
  output logic      [3:0] port0_config,
  output logic      [3:0] port1_config,
  output logic      [3:0] port2_config,
  output logic      [3:0] port3_config,
  output logic      [3:0] left_gain,
  output logic      [3:0] right_gain,
  output logic            mute,
  output logic            power_down
);
  // ---------------- SCL domain ----------------
  logic                rst_scl;
  logic [1:0]          sel_scl;
  logic [1:0]          sel_act_ff;
  logic [7:0]          rd_data_ff;
  logic                start_t_ff;
  logic                stop_t_ff;
  logic                nxt_start_t;
  logic                nxt_stop_t;
  ari_pkg::ari_state_t state_ff, nxt_state;
  logic [3:0]          cnt_ff, nxt_cnt;
  logic [6:0]          shift_ff, nxt_shift;
  logic [7:0]          ptr_ff, nxt_ptr;
  logic [7:0]          tx_ff, nxt_tx;
  logic                ack_req_ff, nxt_ack_req;
  logic                rd_first_ff, nxt_rd_first;
  logic                start_seen_ff, nxt_start_seen;
  logic                stop_seen_ff, nxt_stop_seen;
  logic                wr_t_ff, nxt_wr_t;
  logic [7:0]          wr_addr_ff, nxt_wr_addr;
  logic [7:0]          wr_data_ff, nxt_wr_data;
  logic                rq_t_ff, nxt_rq_t;
  logic [7:0]          rq_addr_ff, nxt_rq_addr;
  logic                ev_t_ff, nxt_ev_t;
  logic [7:0]          ev_addr_ff, nxt_ev_addr;
  logic                frame_t_ff, nxt_frame_t;
  logic                oe_ff, nxt_oe;
  logic                start_pend;
  logic                stop_pend;
  logic [7:0]          byte_in;
  logic [2:0]          tx_idx;

  // The reset level must see a few SCL edges to reach this domain.
  ari_sync #(.W(1)) u_rst_sync (
    .clk (scl),
    .rst (1'b0),
    .d   (sys_rst),
    .q   (rst_scl)
  );

  ari_sync #(.W(2)) u_sel_sync (
    .clk (scl),
    .rst (rst_scl),
    .d   (sel_act_ff),
    .q   (sel_scl)
  );

  // START and STOP are SDA edges while SCL is high, so SDA clocks them.
  always_comb begin
    nxt_start_t = rst_scl ? 1'b0 : (scl ? ~start_t_ff : start_t_ff);
    nxt_stop_t  = rst_scl ? 1'b0 : (scl ? ~stop_t_ff : stop_t_ff);
  end

  always_ff @(negedge sda_in) begin
    start_t_ff <= nxt_start_t;
  end

  always_ff @(posedge sda_in) begin
    stop_t_ff <= nxt_stop_t;
  end

  assign start_pend = start_t_ff ^ start_seen_ff;
  assign stop_pend  = stop_t_ff ^ stop_seen_ff;
  assign byte_in    = {shift_ff, sda_in};

  always_comb begin
    nxt_state      = state_ff;
    nxt_cnt        = cnt_ff;
    nxt_shift      = shift_ff;
    nxt_ptr        = ptr_ff;
    nxt_tx         = tx_ff;
    nxt_ack_req    = ack_req_ff;
    nxt_rd_first   = rd_first_ff;
    nxt_start_seen = start_seen_ff;
    nxt_stop_seen  = stop_seen_ff;
    nxt_wr_t       = wr_t_ff;
    nxt_wr_addr    = wr_addr_ff;
    nxt_wr_data    = wr_data_ff;
    nxt_rq_t       = rq_t_ff;
    nxt_rq_addr    = rq_addr_ff;
    nxt_ev_t       = ev_t_ff;
    nxt_ev_addr    = ev_addr_ff;
    nxt_frame_t    = frame_t_ff;
    if (rst_scl) begin
      nxt_state      = ari_pkg::ST_IDLE;
      nxt_cnt        = '0;
      nxt_shift      = '0;
      nxt_ptr        = ari_pkg::RST_BYTE;
      nxt_tx         = ari_pkg::RST_BYTE;
      nxt_ack_req    = 1'b0;
      nxt_rd_first   = 1'b0;
      nxt_start_seen = start_t_ff;
      nxt_stop_seen  = stop_t_ff;
      nxt_wr_t       = 1'b0;
      nxt_wr_addr    = ari_pkg::RST_BYTE;
      nxt_wr_data    = ari_pkg::RST_BYTE;
      nxt_rq_t       = 1'b0;
      nxt_rq_addr    = ari_pkg::RST_BYTE;
      nxt_ev_t       = 1'b0;
      nxt_ev_addr    = ari_pkg::RST_BYTE;
      nxt_frame_t    = 1'b0;
    end else if (start_pend) begin
      // only a START reopens the bus.
      nxt_start_seen = start_t_ff;
      nxt_stop_seen  = stop_t_ff;
      nxt_state      = ari_pkg::ST_DEVADDR;
      nxt_cnt        = 4'h1;
      nxt_shift      = {6'h00, sda_in};
      nxt_ack_req    = 1'b0;
      nxt_frame_t    = ~frame_t_ff;
    end else if (stop_pend) begin
      nxt_stop_seen = stop_t_ff;
      nxt_state     = ari_pkg::ST_IDLE;
    end else if (state_ff != ari_pkg::ST_IDLE) begin
      nxt_shift = byte_in[6:0];
      nxt_cnt   = (cnt_ff == ari_pkg::BIT_ACK) ? 4'h0 : cnt_ff + 4'h1;
      if (cnt_ff == ari_pkg::BIT_LAST) begin
        case (state_ff)
          ari_pkg::ST_DEVADDR: begin
            // base address plus the selected low bits.
            if (byte_in[7:1] == {ari_pkg::SLAVE_BASE, sel_scl}) begin
              nxt_ack_req  = 1'b1;
              nxt_rd_first = byte_in[0];
              nxt_state    = byte_in[0] ? ari_pkg::ST_RDATA
                                        : ari_pkg::ST_REGADDR;
            end else begin
              // a foreign address drops the frame.
              nxt_state = ari_pkg::ST_IDLE;
            end
          end
          ari_pkg::ST_REGADDR: begin
            nxt_ptr     = byte_in;
            nxt_rq_t    = ~rq_t_ff;
            nxt_rq_addr = byte_in;
            nxt_ack_req = 1'b1;
            nxt_state   = ari_pkg::ST_WDATA;
          end
          ari_pkg::ST_WDATA: begin
            // every data byte of a burst is taken.
            nxt_wr_t    = ~wr_t_ff;
            nxt_wr_addr = ptr_ff;
            nxt_wr_data = byte_in;
            nxt_ptr     = ptr_ff + 8'h01;
            nxt_ack_req = 1'b1;
          end
          default: begin
            nxt_ack_req = 1'b0;
          end
        endcase
      end
      if (cnt_ff == ari_pkg::BIT_ACK) begin
        nxt_ack_req = 1'b0;
        if (state_ff == ari_pkg::ST_RDATA) begin
          if (rd_first_ff || !sda_in) begin
            nxt_tx       = rd_data_ff;
            nxt_ev_t     = ~ev_t_ff;
            nxt_ev_addr  = ptr_ff;
            nxt_ptr      = ptr_ff + 8'h01;
            nxt_rq_t     = ~rq_t_ff;
            nxt_rq_addr  = ptr_ff + 8'h01;
            nxt_rd_first = 1'b0;
          end else begin
            nxt_state = ari_pkg::ST_IDLE;
          end
        end
      end
    end
  end

  always_ff @(posedge scl) begin
    state_ff      <= nxt_state;
    cnt_ff        <= nxt_cnt;
    shift_ff      <= nxt_shift;
    ptr_ff        <= nxt_ptr;
    tx_ff         <= nxt_tx;
    ack_req_ff    <= nxt_ack_req;
    rd_first_ff   <= nxt_rd_first;
    start_seen_ff <= nxt_start_seen;
    stop_seen_ff  <= nxt_stop_seen;
    wr_t_ff       <= nxt_wr_t;
    wr_addr_ff    <= nxt_wr_addr;
    wr_data_ff    <= nxt_wr_data;
    rq_t_ff       <= nxt_rq_t;
    rq_addr_ff    <= nxt_rq_addr;
    ev_t_ff       <= nxt_ev_t;
    ev_addr_ff    <= nxt_ev_addr;
    frame_t_ff    <= nxt_frame_t;
  end

  assign tx_idx = 3'(ari_pkg::BIT_LAST - cnt_ff);

  always_comb begin
    nxt_oe = 1'b0;
    if (rst_scl) begin
      nxt_oe = 1'b0;
    end else if (ack_req_ff) begin
      // hold SDA low through the whole ninth clock.
      nxt_oe = 1'b1;
    end else if (state_ff == ari_pkg::ST_RDATA &&
                 cnt_ff != ari_pkg::BIT_ACK) begin
      nxt_oe = ~tx_ff[tx_idx];
    end
  end

  // SDA changes only while SCL is low, so it is driven on the fall.
  always_ff @(negedge scl) begin
    oe_ff <= nxt_oe;
  end

  assign sda_out = 1'b0;
  assign sda_oe  = oe_ff & ~sys_rst;

  // ---------------- Reference clock domain ----------------
  logic [13:0] pin_s;
  logic [3:0]  tgl_s;
  logic        aud_s, clip_s, jack_s, hot_s, zc_s, int_s;
  logic        wr_p, rq_p, ev_p, frame_p;
  logic [3:0]  seen_ff, nxt_seen;
  logic [7:0]  ctrl_ff, nxt_ctrl;
  logic [1:0]  sel_reg_ff, nxt_sel_reg;
  logic [1:0]  nxt_sel_act;
  logic [7:0]  diag_lo_ff, nxt_diag_lo;
  logic [7:0]  diag_hi_ff, nxt_diag_hi;
  logic [7:0]  gain_reg_ff, nxt_gain_reg;
  logic [7:0]  gain_act_ff, nxt_gain_act;
  logic        gain_pend_ff, nxt_gain_pend;
  logic [3:0]  flags_ff, nxt_flags;
  logic [3:0]  snap_ff, nxt_snap;
  logic [3:0]  pin_q_ff, nxt_pin_q;
  logic        zc_q_ff, nxt_zc_q;
  logic        irq_ff, nxt_irq;
  logic        held_ff, nxt_held;
  logic [7:0]  nxt_rd_data;
  logic [7:0]  comp_img;
  logic [7:0]  rd_mux;
  logic        aud_ev, clip_ev, jack_ev, hot_ev, zc_ev;

  ari_sync #(.W(ari_pkg::PIN_SYNC_W)) u_pin_sync (
    .clk (ref_clk),
    .rst (sys_rst),
    .d   ({audio_detect, clip_detect, jack_sense, overheat, zero_cross,
           int_n_in, comp_upper, comp_lower}),
    .q   (pin_s)
  );

  ari_sync #(.W(ari_pkg::TGL_SYNC_W)) u_tgl_sync (
    .clk (ref_clk),
    .rst (sys_rst),
    .d   ({wr_t_ff, rq_t_ff, ev_t_ff, frame_t_ff}),
    .q   (tgl_s)
  );

  assign {aud_s, clip_s, jack_s, hot_s, zc_s, int_s} = pin_s[13:8];
  assign {wr_p, rq_p, ev_p, frame_p} = tgl_s ^ seen_ff;
  assign aud_ev  = aud_s & ~pin_q_ff[ari_pkg::FL_AUD];
  assign clip_ev = clip_s & ~pin_q_ff[ari_pkg::FL_CLIP];
  assign jack_ev = jack_s ^ pin_q_ff[ari_pkg::FL_JACK];
  assign hot_ev  = hot_s & ~pin_q_ff[ari_pkg::FL_HOT];
  assign zc_ev   = zc_s & ~zc_q_ff;

  always_comb begin
    comp_img = '0;
    for (int i = 0; i < 4; i++) begin
      logic [3:0] cfg;
      cfg = (i < 2) ? diag_lo_ff[i*4 +: 4] : diag_hi_ff[(i-2)*4 +: 4];
      // sensing is on for every state but off and diode.
      if (cfg != ari_pkg::CFG_OFF && cfg != ari_pkg::CFG_DIODE) begin
        comp_img[2*i+1] = pin_s[4+i];
        comp_img[2*i]   = pin_s[i];
      end
    end
  end

  always_comb begin
    case (rq_addr_ff)
      ari_pkg::REG_COMP:    rd_mux = comp_img;
      // die code in the low bits.
      ari_pkg::REG_EVENT:   rd_mux = {flags_ff, 1'b0, DIE_CODE};
      ari_pkg::REG_CTRL:    rd_mux = ctrl_ff;
      ari_pkg::REG_ADDR:    rd_mux = {6'h00, sel_reg_ff};
      ari_pkg::REG_DIAG_LO: rd_mux = diag_lo_ff;
      ari_pkg::REG_DIAG_HI: rd_mux = diag_hi_ff;
      ari_pkg::REG_GAIN:    rd_mux = gain_reg_ff;
      default:              rd_mux = ari_pkg::RST_BYTE;
    endcase
  end

  always_comb begin
    nxt_seen      = tgl_s;
    nxt_ctrl      = ctrl_ff;
    nxt_sel_reg   = sel_reg_ff;
    nxt_sel_act   = sel_act_ff;
    nxt_diag_lo   = diag_lo_ff;
    nxt_diag_hi   = diag_hi_ff;
    nxt_gain_reg  = gain_reg_ff;
    nxt_gain_act  = gain_act_ff;
    nxt_gain_pend = gain_pend_ff;
    nxt_flags     = flags_ff;
    nxt_snap      = snap_ff;
    nxt_pin_q     = {aud_s, clip_s, jack_s, hot_s};
    nxt_zc_q      = zc_s;
    nxt_irq       = irq_ff;
    nxt_rd_data   = rd_data_ff;
    nxt_held      = (frame_p | held_ff) & ~int_s;
    if (rq_p) begin
      nxt_rd_data = rd_mux;
      if (rq_addr_ff == ari_pkg::REG_EVENT) begin
        nxt_snap = flags_ff;
      end
    end
    // only what was sent is cleared; new events survive.
    if (ev_p && ev_addr_ff == ari_pkg::REG_EVENT) begin
      nxt_flags = flags_ff & ~snap_ff;
      nxt_irq   = 1'b0;
    end
    // a pending gain lands on the zero crossing.
    if (gain_pend_ff && zc_ev) begin
      nxt_gain_act  = gain_reg_ff;
      nxt_gain_pend = 1'b0;
    end
    // enables drop when their own interrupt fires.
    if (aud_ev && ctrl_ff[ari_pkg::CTRL_AUD]) begin
      nxt_ctrl[ari_pkg::CTRL_AUD] = 1'b0;
    end
    if (clip_ev && ctrl_ff[ari_pkg::CTRL_CLIP]) begin
      nxt_ctrl[ari_pkg::CTRL_CLIP] = 1'b0;
    end
    if (jack_ev && ctrl_ff[ari_pkg::CTRL_JACK]) begin
      nxt_ctrl[ari_pkg::CTRL_JACK] = 1'b0;
    end
    if ((aud_ev && ctrl_ff[ari_pkg::CTRL_AUD]) ||
        (clip_ev && ctrl_ff[ari_pkg::CTRL_CLIP]) ||
        (jack_ev && ctrl_ff[ari_pkg::CTRL_JACK]) || hot_ev) begin
      nxt_irq = 1'b1;
    end
    // sticky event flags, set wins over clear.
    if (aud_ev) nxt_flags[ari_pkg::FL_AUD] = 1'b1;
    if (clip_ev) nxt_flags[ari_pkg::FL_CLIP] = 1'b1;
    if (hot_ev) nxt_flags[ari_pkg::FL_HOT] = 1'b1;
    // jack flag takes the new jack state.
    if (jack_ev) nxt_flags[ari_pkg::FL_JACK] = jack_s;
    if (wr_p) begin
      case (wr_addr_ff)
        ari_pkg::REG_CTRL: begin
          // enables, zero cross, mute and shutdown.
          nxt_ctrl = wr_data_ff & ari_pkg::CTRL_MASK;
        end
        ari_pkg::REG_ADDR: begin
          nxt_sel_reg = wr_data_ff[1:0];
          // applied only with the pin held low all along.
          if (held_ff && !int_s) begin
            nxt_sel_act = wr_data_ff[1:0];
          end
        end
        ari_pkg::REG_DIAG_LO: nxt_diag_lo = wr_data_ff;
        ari_pkg::REG_DIAG_HI: nxt_diag_hi = wr_data_ff;
        ari_pkg::REG_GAIN: begin
          nxt_gain_reg = wr_data_ff;
          if (ctrl_ff[ari_pkg::CTRL_ZC]) begin
            nxt_gain_pend = 1'b1;
          end else begin
            nxt_gain_act  = wr_data_ff;
            nxt_gain_pend = 1'b0;
          end
        end
        default: nxt_gain_pend = nxt_gain_pend;
      endcase
    end
    if (sys_rst) begin
      nxt_ctrl      = ari_pkg::RST_BYTE;
      nxt_sel_reg   = ari_pkg::SEL_RST;
      nxt_sel_act   = ari_pkg::SEL_RST;
      nxt_diag_lo   = ari_pkg::RST_BYTE;
      nxt_diag_hi   = ari_pkg::RST_BYTE;
      nxt_gain_reg  = ari_pkg::RST_BYTE;
      nxt_gain_act  = ari_pkg::RST_BYTE;
      nxt_gain_pend = 1'b0;
      nxt_flags     = '0;
      nxt_snap      = '0;
      nxt_pin_q     = '0;
      nxt_zc_q      = 1'b0;
      nxt_irq       = 1'b0;
      nxt_rd_data   = ari_pkg::RST_BYTE;
      nxt_held      = 1'b0;
      nxt_seen      = '0;
    end
  end

  always_ff @(posedge ref_clk) begin
    seen_ff      <= nxt_seen;
    ctrl_ff      <= nxt_ctrl;
    sel_reg_ff   <= nxt_sel_reg;
    sel_act_ff   <= nxt_sel_act;
    diag_lo_ff   <= nxt_diag_lo;
    diag_hi_ff   <= nxt_diag_hi;
    gain_reg_ff  <= nxt_gain_reg;
    gain_act_ff  <= nxt_gain_act;
    gain_pend_ff <= nxt_gain_pend;
    flags_ff     <= nxt_flags;
    snap_ff      <= nxt_snap;
    pin_q_ff     <= nxt_pin_q;
    zc_q_ff      <= nxt_zc_q;
    irq_ff       <= nxt_irq;
    rd_data_ff   <= nxt_rd_data;
    held_ff      <= nxt_held;
  end

  assign int_n_out    = 1'b0;
  assign int_n_oe     = irq_ff;
  assign port0_config = diag_lo_ff[3:0];
  assign port1_config = diag_lo_ff[7:4];
  assign port2_config = diag_hi_ff[3:0];
  assign port3_config = diag_hi_ff[7:4];
  assign left_gain    = gain_act_ff[7:4];
  assign right_gain   = gain_act_ff[3:0];
  // mute and shutdown straight from the control register.
  assign mute         = ctrl_ff[ari_pkg::CTRL_MUTE];
  assign power_down   = ctrl_ff[ari_pkg::CTRL_PD];
endmodule

// ---- logic/ari_sync.sv ----
`timescale 1ns/1ps
module ari_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;
  logic [W-1:0] nxt_meta;
  logic [W-1:0] nxt_sync;

  always_comb begin
    nxt_meta = rst ? '0 : d;
    nxt_sync = rst ? '0 : meta_ff;
  end

  always_ff @(posedge clk) begin
    meta_ff <= nxt_meta;
    sync_ff <= nxt_sync;
  end

  assign q = sync_ff;
endmodule
